// ### hdl/lap_proc.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`include "lap_defines.svh"
module lap_proc
	import lap_pkg::*;
#(
	parameter int TICK_CYC = `LAP_TICK_CYC
)
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	input wire logic rx_valid_i,
	input wire lap_rx_t rx_i,
	input wire logic local_busy_i,
	input wire logic i_sent_i,
	input wire logic np_tx_req_i,
	input wire logic np_insert_i,
	input wire logic np_crc_i,
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output lap_tx_t tx_o,
	output logic i_tx_en_o,
	output logic rewind_valid_o,
	output logic [6:0] rewind_ns_o,
	output logic ack_valid_o,
	output logic [6:0] ack_last_o,
	output logic deliver_valid_o,
	output lap_dlv_t deliver_o,
	output logic err_valid_o,
	output logic [7:0] err_code_o,
	output logic np_tx_valid_o,
	output lap_np_tx_t np_tx_o
);
	logic dmi_q, frmr_opt_q, len_mask_q, mask_en_q, nonprot_q, crc_dlv_q;
	logic active_q;
	logic [15:0] n201_q, t200_q, addr_q, tick_q, t200_cnt_q;
	logic [7:0] nonstd_q;
	lap_state_t state_q, state_d;
	logic [6:0] va_q, vs_q, vr_q;
	logic peer_busy_q, poll_q, t200_run_q, tick, t200_exp;
	logic resp_pend_q, frmr_pend_q, sabme_pend_q, spoll_pend_q;
	lap_kind_t resp_kind_q, resp_kind_d, spoll_kind_q;
	logic resp_f_q, resp_f_d, take;
	lap_tx_t tx_q;
	logic nr_ok, nr_adv, nr_out, ns_ok;
	logic rx_ok, prot, conn, is_s, undef, bad_info, bad_len, len_over;
	logic fr, t_stop, t_restart, pb_set, pb_clr, va_ld, rej_ld, vr_inc;
	logic dlv, resp_set, frmr_set, sabme_set, err_set, poll_clr, seq_clr;
	logic [7:0] err_code;
	logic cmd_wr;

	lap_seq_chk u_seq (
		.va_i(va_q),
		.vs_i(vs_q),
		.vr_i(vr_q),
		.nr_i(rx_i.nr),
		.ns_i(rx_i.ns),
		.nr_ok_o(nr_ok),
		.nr_adv_o(nr_adv),
		.nr_out_o(nr_out),
		.ns_ok_o(ns_ok)
	);

	assign cmd_wr = reg_we_i && reg_addr_i == `LAP_REG_CMD;
	// Link active only once the host has issued the activation command
	assign rx_ok = rx_valid_i && active_q &&
		rx_i.frame_len >= `LAP_MIN_LEN &&
		((rx_i.addr ^ addr_q) & (nonprot_q ? `LAP_NP_MASK : 16'hffff))
		== 16'h0000;
	assign prot = rx_ok && !nonprot_q && rx_i.crc_ok && rx_i.err_free;
	assign conn = state_q == LS_MF_NORMAL || state_q == LS_MF_REJECT;
	assign is_s = rx_i.kind inside {LK_RR, LK_RNR, LK_REJ};
	assign undef = rx_i.kind == LK_UNDEF && rx_i.ctrl != nonstd_q;
	assign bad_info = rx_i.info_len != 16'h0000 &&
		(is_s || rx_i.kind inside {LK_SABME, LK_UA, LK_DM, LK_DISC});
	assign bad_len = rx_i.kind == LK_FRMR && rx_i.info_len != `LAP_FRMR_LEN;
	assign len_over = rx_i.info_len > n201_q &&
		!(mask_en_q && len_mask_q);
	assign tick = tick_q == 16'h0000;
	assign t200_exp = t200_run_q && tick && t200_cnt_q <= 16'h0001;
	assign take = !tx_valid_o || tx_ready_i;

	always_comb
	begin
		t_stop = 1'b0;
		t_restart = 1'b0;
		pb_set = 1'b0;
		pb_clr = 1'b0;
		va_ld = 1'b0;
		rej_ld = 1'b0;
		vr_inc = 1'b0;
		dlv = 1'b0;
		resp_set = 1'b0;
		resp_kind_d = LK_RR;
		resp_f_d = 1'b0;
		frmr_set = 1'b0;
		sabme_set = 1'b0;
		err_set = 1'b0;
		err_code = `LAP_ERR_A;
		poll_clr = 1'b0;
		seq_clr = 1'b0;
		fr = 1'b0;
		state_d = state_q;
		if (rx_ok && nonprot_q)
			dlv = rx_i.crc_ok || crc_dlv_q;
		else if (prot && conn) begin
			if (undef || bad_info || bad_len ||
				(rx_i.kind == LK_I && len_over) || (is_s && !nr_ok))
			begin
				fr = 1'b1;
				err_code = undef ? `LAP_ERR_L : bad_info ? `LAP_ERR_M :
					bad_len ? `LAP_ERR_N : !nr_ok ? `LAP_ERR_J : `LAP_ERR_O;
			end
			else if (rx_i.kind == LK_I) begin
				// CCITT answers first even when N(R) is bad
				if (nr_ok || !dmi_q)
				begin
					resp_set = 1'b1;
					resp_f_d = rx_i.pf;
					if (local_busy_i)
						resp_kind_d = LK_RNR;
					else if (ns_ok) begin
						dlv = 1'b1;
						vr_inc = 1'b1;
						state_d = LS_MF_NORMAL;
					end
					else if (state_q == LS_MF_NORMAL) begin
						resp_kind_d = LK_REJ;
						state_d = LS_MF_REJECT;
					end
				end
				if (!nr_ok) begin
					fr = 1'b1;
					err_code = `LAP_ERR_J;
				end
				else begin
					va_ld = 1'b1;
					t_stop = nr_adv;
					t_restart = nr_adv && nr_out;
				end
			end
			else if (is_s) begin
				if (!rx_i.cmd && rx_i.pf && !poll_q) begin
					err_set = 1'b1;
					err_code = `LAP_ERR_A;
				end
				if (!(dmi_q && !rx_i.cmd && rx_i.pf && !poll_q)) begin
					va_ld = 1'b1;
					t_stop = nr_adv ||
						(rx_i.kind == LK_REJ && !nr_adv);
					t_restart = nr_adv && nr_out &&
						rx_i.kind != LK_REJ;
				end
				if (rx_i.kind == LK_RNR) begin
					pb_set = 1'b1;
					t_restart = 1'b1;
				end
				else
					pb_clr = 1'b1;
				if (rx_i.kind == LK_REJ)
					rej_ld = 1'b1;
				if (!rx_i.cmd && rx_i.pf && poll_q) begin
					poll_clr = 1'b1;
					if (rx_i.kind != LK_RNR) begin
						t_stop = 1'b1;
						t_restart = 1'b0;
					end
				end
				if (rx_i.cmd && rx_i.pf) begin
					resp_set = 1'b1;
					resp_f_d = 1'b1;
					resp_kind_d = local_busy_i ? LK_RNR :
						state_q == LS_MF_REJECT ? LK_REJ : LK_RR;
				end
			end
			else if (rx_i.kind == LK_DM && !rx_i.cmd && rx_i.pf) begin
				err_set = 1'b1;
				err_code = `LAP_ERR_B;
				if (dmi_q) begin
					sabme_set = 1'b1;
					state_d = LS_AWAITING_ESTABLISHMENT;
				end
			end
		end
		else if (prot && state_q == LS_AWAITING_ESTABLISHMENT &&
			rx_i.kind == LK_UA) begin
			seq_clr = 1'b1;
			t_stop = 1'b1;
			state_d = LS_MF_NORMAL;
		end
		if (fr) begin
			err_set = 1'b1;
			frmr_set = frmr_opt_q;
			sabme_set = 1'b1;
			t_stop = 1'b1;
			t_restart = 1'b0;
			pb_clr = 1'b1;
			state_d = LS_AWAITING_ESTABLISHMENT;
		end
		if (cmd_wr) begin
			if (reg_wdata_i[`LAP_CMD_ACTIVATE])
				state_d = LS_TEI_UNASSIGNED;
			else if (reg_wdata_i[`LAP_CMD_ESTABLISH] &&
				state_q == LS_TEI_UNASSIGNED)
				state_d = LS_AWAITING_TEI_ASSIGNMENT;
			else if (reg_wdata_i[`LAP_CMD_ASSIGN] &&
				state_q == LS_AWAITING_TEI_ASSIGNMENT) begin
				state_d = LS_AWAITING_ESTABLISHMENT;
				sabme_set = 1'b1;
			end
			else if (reg_wdata_i[`LAP_CMD_RELEASE] && dmi_q &&
				state_q == LS_AWAITING_TEI_ASSIGNMENT) begin
				state_d = LS_TEI_UNASSIGNED;
				err_set = 1'b1;
				err_code = `LAP_ERR_G;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i) begin
			{dmi_q, frmr_opt_q, len_mask_q} <= 3'h0;
			{mask_en_q, nonprot_q, crc_dlv_q, active_q} <= 4'h0;
			n201_q <= `LAP_N201_RST;
			t200_q <= `LAP_T200_RST;
			addr_q <= `LAP_ADDR_RST;
			nonstd_q <= `LAP_NONSTD_RST;
		end
		else if (ce_i && reg_we_i)
			unique case (reg_addr_i)
				`LAP_REG_CTRL:
				begin
					dmi_q <= reg_wdata_i[`LAP_CTRL_DMI];
					frmr_opt_q <= reg_wdata_i[`LAP_CTRL_FRMR];
					len_mask_q <= reg_wdata_i[`LAP_CTRL_LENMASK];
					mask_en_q <= reg_wdata_i[`LAP_CTRL_MASKEN];
					nonprot_q <= reg_wdata_i[`LAP_CTRL_NONPROT];
					crc_dlv_q <= reg_wdata_i[`LAP_CTRL_CRCDLV];
				end
				`LAP_REG_N201: n201_q <= reg_wdata_i[15:0];
				`LAP_REG_T200: t200_q <= reg_wdata_i[15:0];
				`LAP_REG_ADDR: addr_q <= reg_wdata_i[15:0];
				`LAP_REG_NONSTD: nonstd_q <= reg_wdata_i[7:0];
				`LAP_REG_CMD:
					if (reg_wdata_i[`LAP_CMD_ACTIVATE])
						active_q <= 1'b1;
				default:
				begin
				end
			endcase

	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i)
			reg_rdata_o <= 32'h0000_0000;
		else if (ce_i && reg_re_i)
			unique case (reg_addr_i)
				`LAP_REG_CTRL: reg_rdata_o <= {25'h0, active_q, crc_dlv_q,
					nonprot_q, mask_en_q, len_mask_q, frmr_opt_q, dmi_q};
				`LAP_REG_N201: reg_rdata_o <= {16'h0, n201_q};
				`LAP_REG_T200: reg_rdata_o <= {16'h0, t200_q};
				`LAP_REG_ADDR: reg_rdata_o <= {16'h0, addr_q};
				`LAP_REG_NONSTD: reg_rdata_o <= {24'h0, nonstd_q};
				`LAP_REG_STATUS: reg_rdata_o <= {20'h0, resp_pend_q,
					poll_q, t200_run_q, peer_busy_q, 3'h0, state_q};
				`LAP_REG_SEQ: reg_rdata_o <= {9'h0, vr_q, 1'b0, vs_q,
					1'b0, va_q};
				default: reg_rdata_o <= 32'h0000_0000;
			endcase

	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i)
			state_q <= LS_TEI_UNASSIGNED;
		else if (ce_i)
			state_q <= state_d;

	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i) begin
			va_q <= 7'h00;
			vs_q <= 7'h00;
			vr_q <= 7'h00;
		end
		else if (ce_i) begin
			if (seq_clr) begin
				va_q <= 7'h00;
				vs_q <= 7'h00;
				vr_q <= 7'h00;
			end
			else begin
				if (va_ld || rej_ld)
					va_q <= rx_i.nr;
				if (rej_ld)
					vs_q <= rx_i.nr;
				else if (i_sent_i)
					vs_q <= 7'(vs_q + 7'h01);
				if (vr_inc)
					vr_q <= 7'(vr_q + 7'h01);
			end
		end

	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i) begin
			tick_q <= 16'h0000;
			t200_run_q <= 1'b0;
			t200_cnt_q <= 16'h0000;
		end
		else if (ce_i) begin
			tick_q <= tick ? 16'(TICK_CYC - 1) : 16'(tick_q - 16'h0001);
			if (t_restart || t200_exp) begin
				t200_run_q <= 1'b1;
				t200_cnt_q <= t200_q;
			end
			else if (t_stop)
				t200_run_q <= 1'b0;
			else if (i_sent_i && !t200_run_q) begin
				t200_run_q <= 1'b1;
				t200_cnt_q <= t200_q;
			end
			else if (t200_run_q && tick)
				t200_cnt_q <= 16'(t200_cnt_q - 16'h0001);
		end

	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i) begin
			peer_busy_q <= 1'b0;
			poll_q <= 1'b0;
		end
		else if (ce_i) begin
			if (pb_set)
				peer_busy_q <= 1'b1;
			else if (pb_clr)
				peer_busy_q <= 1'b0;
			if (t200_exp && conn)
				poll_q <= 1'b1;
			else if (poll_clr || fr)
				poll_q <= 1'b0;
		end

	// Pending frames: a new request in the taking cycle stays pending
	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i) begin
			{resp_pend_q, frmr_pend_q, sabme_pend_q, spoll_pend_q} <= 4'h0;
			resp_kind_q <= LK_RR;
			resp_f_q <= 1'b0;
			spoll_kind_q <= LK_RR;
			tx_valid_o <= 1'b0;
			tx_q <= '{kind: LK_RR, cmd: 1'b0, pf: 1'b0};
		end
		else if (ce_i) begin
			resp_pend_q <= (resp_pend_q && !take) || resp_set;
			frmr_pend_q <= (frmr_pend_q && !(take && !resp_pend_q)) ||
				frmr_set;
			sabme_pend_q <= (sabme_pend_q && !(take && !resp_pend_q &&
				!frmr_pend_q)) || sabme_set;
			spoll_pend_q <= (spoll_pend_q && !(take && !resp_pend_q &&
				!frmr_pend_q && !sabme_pend_q)) || (t200_exp && conn);
			if (resp_set) begin
				resp_kind_q <= resp_kind_d;
				resp_f_q <= resp_f_d;
			end
			if (t200_exp)
				spoll_kind_q <= local_busy_i ? LK_RNR : LK_RR;
			if (take) begin
				tx_valid_o <= resp_pend_q || frmr_pend_q || sabme_pend_q ||
					spoll_pend_q;
				if (resp_pend_q)
					tx_q <= '{kind: resp_kind_q, cmd: 1'b0, pf: resp_f_q};
				else if (frmr_pend_q)
					tx_q <= '{kind: LK_FRMR, cmd: 1'b0, pf: 1'b0};
				else if (sabme_pend_q)
					tx_q <= '{kind: LK_SABME, cmd: 1'b1, pf: 1'b1};
				else if (spoll_pend_q)
					tx_q <= '{kind: spoll_kind_q, cmd: 1'b1, pf: 1'b1};
			end
		end
	assign tx_o = tx_q;

	// I frames wait behind peer busy and any queued F response
	assign i_tx_en_o = active_q && !nonprot_q && conn &&
		!peer_busy_q && !resp_pend_q &&
		!(tx_valid_o && !tx_q.cmd && tx_q.pf);

	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i) begin
			{rewind_valid_o, ack_valid_o, deliver_valid_o} <= 3'h0;
			{err_valid_o, np_tx_valid_o} <= 2'h0;
			rewind_ns_o <= 7'h00;
			ack_last_o <= 7'h00;
			deliver_o <= '0;
			err_code_o <= 8'h00;
			np_tx_o <= '0;
		end
		else if (ce_i) begin
			rewind_valid_o <= rej_ld;
			rewind_ns_o <= rx_i.nr;
			ack_valid_o <= (va_ld || rej_ld) && nr_adv;
			ack_last_o <= 7'(rx_i.nr - 7'h01);
			deliver_valid_o <= dlv;
			deliver_o <= '{addr: rx_i.addr, crc_err: !rx_i.crc_ok,
				nonprot: nonprot_q};
			err_valid_o <= err_set;
			err_code_o <= err_code;
			np_tx_valid_o <= np_tx_req_i && active_q && nonprot_q;
			np_tx_o <= '{insert_addr: np_insert_i, append_crc: np_crc_i,
				dlci: addr_q};
		end
endmodule

// ### hdl/lap_seq_chk.sv
`timescale 1ns/1ps
module lap_seq_chk
	import lap_pkg::*;
(
	input wire logic [6:0] va_i,
	input wire logic [6:0] vs_i,
	input wire logic [6:0] vr_i,
	input wire logic [6:0] nr_i,
	input wire logic [6:0] ns_i,
	output logic nr_ok_o,
	output logic nr_adv_o,
	output logic nr_out_o,
	output logic ns_ok_o
);
	function automatic logic [6:0] seq_dist(input logic [6:0] from,
		input logic [6:0] to);
		seq_dist = 7'(to - from);
	endfunction

	// Window check V(A) <= N(R) <= V(S), modulo 128
	assign nr_ok_o = seq_dist(va_i, nr_i) <= seq_dist(va_i, vs_i);
	assign nr_adv_o = seq_dist(va_i, nr_i) != 7'h00;
	assign nr_out_o = seq_dist(nr_i, vs_i) != 7'h00;
	assign ns_ok_o = ns_i == vr_i;
endmodule

// ### include/lap_defines.svh
`ifndef LAP_DEFINES_SVH
`define LAP_DEFINES_SVH
`define LAP_REG_CTRL 3'h0
`define LAP_REG_N201 3'h1
`define LAP_REG_T200 3'h2
`define LAP_REG_ADDR 3'h3
`define LAP_REG_NONSTD 3'h4
`define LAP_REG_CMD 3'h5
`define LAP_REG_STATUS 3'h6
`define LAP_REG_SEQ 3'h7
`define LAP_CTRL_DMI 0
`define LAP_CTRL_FRMR 1
`define LAP_CTRL_LENMASK 2
`define LAP_CTRL_MASKEN 3
`define LAP_CTRL_NONPROT 4
`define LAP_CTRL_CRCDLV 5
`define LAP_CMD_ACTIVATE 0
`define LAP_CMD_ESTABLISH 1
`define LAP_CMD_ASSIGN 2
`define LAP_CMD_RELEASE 3
`define LAP_N201_RST 16'h0104
`define LAP_T200_RST 16'h03e8
`define LAP_ADDR_RST 16'h0000
`define LAP_NONSTD_RST 8'h00
`define LAP_CLK_NS 20
`define LAP_TICK_NS 1000000
`define LAP_TICK_CYC (`LAP_TICK_NS / `LAP_CLK_NS)
`define LAP_MIN_LEN 16'h0005
`define LAP_FRMR_LEN 16'h0005
`define LAP_NP_MASK 16'hfefc
`define LAP_ERR_A 8'h41
`define LAP_ERR_B 8'h42
`define LAP_ERR_G 8'h47
`define LAP_ERR_J 8'h4a
`define LAP_ERR_L 8'h4c
`define LAP_ERR_M 8'h4d
`define LAP_ERR_N 8'h4e
`define LAP_ERR_O 8'h4f
`endif

// ### include/lap_pkg.sv
package lap_pkg;
	typedef enum logic [3:0] {
		LK_I, LK_RR, LK_RNR, LK_REJ, LK_SABME, LK_UA, LK_DM,
		LK_FRMR, LK_DISC, LK_UI, LK_XID, LK_UNDEF
	} lap_kind_t;
	typedef enum logic [4:0] {
		LS_TEI_UNASSIGNED = 5'h01,
		LS_AWAITING_TEI_ASSIGNMENT = 5'h02,
		LS_AWAITING_ESTABLISHMENT = 5'h04,
		LS_MF_NORMAL = 5'h08,
		LS_MF_REJECT = 5'h10
	} lap_state_t;
	typedef struct packed {
		lap_kind_t kind;
		logic cmd;
		logic pf;
		logic [6:0] ns;
		logic [6:0] nr;
		logic [7:0] ctrl;
		logic [15:0] info_len;
		logic [15:0] frame_len;
		logic [15:0] addr;
		logic crc_ok;
		logic err_free;
	} lap_rx_t;
	typedef struct packed {
		lap_kind_t kind;
		logic cmd;
		logic pf;
	} lap_tx_t;
	typedef struct packed {
		logic [15:0] addr;
		logic crc_err;
		logic nonprot;
	} lap_dlv_t;
	typedef struct packed {
		logic insert_addr;
		logic append_crc;
		logic [15:0] dlci;
	} lap_np_tx_t;
endpackage

// ### sim/lap_peer.sv
`timescale 1ns/1ps
module lap_peer
	import lap_pkg::*;
(
	input wire logic clk_i,
	input wire logic slow_i,
	input wire logic tx_valid_i,
	input wire lap_tx_t tx_i,
	output logic tx_ready_o,
	output logic rx_valid_o,
	output lap_rx_t rx_o
);
	logic [1:0] stall_q = 2'h0;
	initial
	begin
		tx_ready_o = 1'b1;
		rx_valid_o = 1'b0;
		rx_o = '1;
	end
	// Slow mode takes a queued frame only every fourth cycle
	always @(posedge clk_i)
	begin
		stall_q <= stall_q + 2'h1;
		tx_ready_o <= !slow_i || stall_q == 2'h0;
	end
	task automatic send_frame(input lap_kind_t k, input logic c,
		input logic pf, input logic [6:0] nr, input logic [15:0] adr,
		input logic [15:0] len, input logic crc);
		lap_rx_t f;
		f = '0;
		f.kind = k;
		f.cmd = c;
		f.pf = pf;
		f.nr = nr;
		f.ctrl = (k == LK_UNDEF) ? 8'hff : 8'h01;
		f.frame_len = len;
		f.addr = adr;
		f.crc_ok = crc;
		f.err_free = 1'b1;
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_o <= f;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_o <= ~f;
	endtask
endmodule

// ### sim/lap_proc_sva.sv
`timescale 1ns/1ps
`include "lap_defines.svh"
module lap_proc_sva
	import lap_pkg::*;
#(
	parameter int TICK_CYC = 4
)
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic rx_valid_i,
	input wire lap_rx_t rx_i,
	input wire logic np_tx_req_i,
	input wire logic np_insert_i,
	input wire logic np_crc_i,
	input wire logic tx_ready_i,
	input wire logic tx_valid_o,
	input wire lap_tx_t tx_o,
	input wire logic i_tx_en_o,
	input wire logic rewind_valid_o,
	input wire logic [6:0] rewind_ns_o,
	input wire logic ack_valid_o,
	input wire logic [6:0] ack_last_o,
	input wire logic deliver_valid_o,
	input wire lap_dlv_t deliver_o,
	input wire logic err_valid_o,
	input wire logic [7:0] err_code_o,
	input wire logic np_tx_valid_o,
	input wire lap_np_tx_t np_tx_o
);
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	sequence frmr_taken_s;
		tx_valid_o && tx_ready_i && tx_o.kind == LK_FRMR;
	endsequence
	sequence sabme_soon_s;
		##[1:2] tx_valid_o && tx_o.kind == LK_SABME;
	endsequence
	ack_map_a:
		assert property (ack_valid_o |-> $past(rx_valid_i)
			&& ack_last_o == 7'($past(rx_i.nr) - 7'h01))
		else $error("ack pulse does not follow received N(R)");
	rewind_a:
		assert property (rewind_valid_o |-> $past(rx_valid_i)
			&& rewind_ns_o == $past(rx_i.nr))
		else $error("rewind value does not follow received N(R)");
	tx_hold_a:
		assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
			&& $stable(tx_o))
		else $error("queued frame changed before it was taken");
	resp_first_a:
		assert property (rewind_valid_o && tx_valid_o && tx_o.pf
			&& !tx_o.cmd |-> !i_tx_en_o)
		else $error("I frames enabled before final response");
	peer_busy_a:
		assert property ($past(rx_valid_i && rx_i.kind == LK_RNR)
			&& ack_valid_o |-> !i_tx_en_o)
		else $error("I frames enabled while peer busy");
	frmr_order_a:
		assert property (frmr_taken_s |-> sabme_soon_s)
		else $error("setup frame does not follow reject frame");
	reject_tx_a:
		assert property (err_valid_o && err_code_o inside {`LAP_ERR_L,
			`LAP_ERR_M, `LAP_ERR_N, `LAP_ERR_O} |-> ##[0:16]
			tx_valid_o && tx_o.kind inside {LK_FRMR, LK_SABME})
		else $error("reject report without reset frame");
	np_opts_a:
		assert property (np_tx_valid_o |-> $past(np_tx_req_i)
			&& np_tx_o.insert_addr == $past(np_insert_i)
			&& np_tx_o.append_crc == $past(np_crc_i))
		else $error("nonprotocol transmit options wrong");
	deliver_a:
		assert property (deliver_valid_o |-> $past(rx_valid_i)
			&& $past(rx_i.frame_len) >= 16'h0005
			&& deliver_o.addr == $past(rx_i.addr))
		else $error("delivered frame short or address wrong");
endmodule
bind lap_proc lap_proc_sva #(.TICK_CYC(TICK_CYC)) i_lap_proc_sva (
	.clk_i(clk_i), .reset_i(reset_i), .rx_valid_i(rx_valid_i),
	.rx_i(rx_i), .np_tx_req_i(np_tx_req_i), .np_insert_i(np_insert_i),
	.np_crc_i(np_crc_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
	.tx_o(tx_o), .i_tx_en_o(i_tx_en_o), .rewind_valid_o(rewind_valid_o),
	.rewind_ns_o(rewind_ns_o), .ack_valid_o(ack_valid_o),
	.ack_last_o(ack_last_o), .deliver_valid_o(deliver_valid_o),
	.deliver_o(deliver_o), .err_valid_o(err_valid_o),
	.err_code_o(err_code_o), .np_tx_valid_o(np_tx_valid_o),
	.np_tx_o(np_tx_o)
);

// ### sim/tb_top.sv
`timescale 1ns/1ps
`include "lap_defines.svh"
module tb_top
	import lap_pkg::*;
;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [2:0] reg_addr_i = 3'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_we_i = 1'b0;
	logic reg_re_i = 1'b0;
	logic i_sent_i = 1'b0;
	logic np_tx_req_i = 1'b0;
	logic np_insert_i = 1'b0;
	logic np_crc_i = 1'b0;
	logic slow = 1'b0;
	logic busy = 1'b0;
	logic re_seen = 1'b0;
	logic rx_valid_i, tx_ready_i, tx_valid_o, i_tx_en_o, rewind_valid_o;
	logic ack_valid_o, deliver_valid_o, err_valid_o, np_tx_valid_o;
	logic [31:0] reg_rdata_o, r;
	logic [6:0] rewind_ns_o, ack_last_o;
	logic [7:0] err_code_o;
	logic [15:0] la;
	lap_rx_t rx_i;
	lap_tx_t tx_o;
	lap_dlv_t deliver_o;
	lap_np_tx_t np_tx_o;
	logic [63:0] exp_q[7][$];
	int n_errors = 0;
	int check_count = 0;
	always #10 clk_i = ~clk_i;
	lap_proc #(.TICK_CYC(4)) i_lap_proc (.clk_i(clk_i), .reset_i(reset_i),
		.ce_i(1'b1), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.rx_valid_i(rx_valid_i), .rx_i(rx_i), .local_busy_i(busy),
		.i_sent_i(i_sent_i), .np_tx_req_i(np_tx_req_i),
		.np_insert_i(np_insert_i), .np_crc_i(np_crc_i),
		.tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o), .tx_o(tx_o),
		.i_tx_en_o(i_tx_en_o), .rewind_valid_o(rewind_valid_o),
		.rewind_ns_o(rewind_ns_o), .ack_valid_o(ack_valid_o),
		.ack_last_o(ack_last_o), .deliver_valid_o(deliver_valid_o),
		.deliver_o(deliver_o), .err_valid_o(err_valid_o),
		.err_code_o(err_code_o), .np_tx_valid_o(np_tx_valid_o),
		.np_tx_o(np_tx_o));
	lap_peer i_lap_peer (.clk_i(clk_i), .slow_i(slow),
		.tx_valid_i(tx_valid_o), .tx_i(tx_o), .tx_ready_o(tx_ready_i),
		.rx_valid_o(rx_valid_i), .rx_o(rx_i));
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic fail(input string m);
		n_errors++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task automatic ex(input int s, input logic [31:0] v,
		input logic [31:0] m = 32'hffffffff);
		exp_q[s].push_back({m, v});
	endtask
	task automatic got(input int s, input logic [31:0] v);
		logic [63:0] e;
		check_count++;
		if (exp_q[s].size() == 0)
			fail($sformatf("unexpected event on source %0d", s));
		else
		begin
			e = exp_q[s].pop_front();
			if ((v & e[63:32]) !== e[31:0])
				fail($sformatf("source %0d got %h want %h", s, v, e[31:0]));
		end
	endtask
	// Monitor: 0 ack, 1 rewind, 2 error, 3 tx, 4 np tx, 5 deliver, 6 read
	always @(posedge clk_i)
	begin
		re_seen <= reg_re_i;
		if (ack_valid_o) got(0, {25'h0, ack_last_o});
		if (rewind_valid_o) got(1, {25'h0, rewind_ns_o});
		if (err_valid_o) got(2, {24'h0, err_code_o});
		if (tx_valid_o && tx_ready_i) got(3, {26'h0, tx_o});
		if (np_tx_valid_o) got(4, {14'h0, np_tx_o});
		if (deliver_valid_o) got(5, {14'h0, deliver_o});
		if (re_seen) got(6, reg_rdata_o);
	end
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [31:0] v,
		input logic [31:0] m = 32'hffffffff);
		@(posedge clk_i);
		ex(6, v, m);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
	endtask
	task automatic rx(input lap_kind_t k, input logic c, input logic p,
		input logic [6:0] nr);
		i_lap_peer.send_frame(k, c, p, nr, la,
			(k inside {LK_RR, LK_RNR, LK_REJ}) ? 16'h0006 : 16'h0005, 1'b1);
	endtask
	function automatic logic [31:0] txw(input lap_kind_t k, input logic c,
		input logic p);
		return {26'h0, k, c, p};
	endfunction
	task automatic settle(input string name);
		int n;
		n = 0;
		while ((exp_q[0].size() + exp_q[1].size() + exp_q[2].size()
			+ exp_q[3].size() + exp_q[4].size() + exp_q[5].size()
			+ exp_q[6].size()) != 0 && n < 300)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 300)
		begin
			fail("expected events missing");
			wrap_up;
		end
		else
		begin
			repeat (3) @(posedge clk_i);
			$display("Test %s done", name);
		end
	endtask
	initial
	begin
		r = $urandom(32'he7c61a33);
		la = 16'($urandom()) & `LAP_NP_MASK;
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(`LAP_REG_N201, 32'h104);
		rd(`LAP_REG_T200, 32'h3e8);
		rd(`LAP_REG_ADDR, 32'h0);
		rd(`LAP_REG_NONSTD, 32'h0);
		rd(`LAP_REG_CMD, 32'h0);
		rd(`LAP_REG_STATUS, 32'h01, 32'h1f);
		settle("reset values");
		wr(`LAP_REG_ADDR, {16'h0, la});
		wr(`LAP_REG_T200, 32'h14);
		wr(`LAP_REG_CTRL, 32'h2);
		wr(`LAP_REG_CMD, 32'h1);
		wr(`LAP_REG_CMD, 32'h2);
		ex(3, txw(LK_SABME, 1'b1, 1'b1));
		wr(`LAP_REG_CMD, 32'h4);
		i_lap_peer.send_frame(LK_UA, 1'b0, 1'b1, 7'h0, la, 16'h4, 1'b1);
		rd(`LAP_REG_STATUS, 32'h04, 32'h1f);
		rx(LK_UA, 1'b0, 1'b1, 7'h0);
		rd(`LAP_REG_STATUS, 32'h08, 32'h1f);
		settle("setup");
		repeat (5)
		begin
			@(posedge clk_i);
			i_sent_i <= 1'b1;
			@(posedge clk_i);
			i_sent_i <= 1'b0;
		end
		rd(`LAP_REG_SEQ, 32'h0500, 32'h7f7f7f);
		ex(0, 32'h1);
		rx(LK_RR, 1'b0, 1'b0, 7'h2);
		settle("acknowledge");
		slow <= 1'b1;
		ex(0, 32'h2);
		ex(1, 32'h3);
		ex(3, txw(LK_RR, 1'b0, 1'b1));
		rx(LK_REJ, 1'b1, 1'b1, 7'h3);
		rd(`LAP_REG_SEQ, 32'h0303, 32'h7f7f7f);
		settle("reject");
		slow <= 1'b0;
		@(posedge clk_i);
		i_sent_i <= 1'b1;
		@(posedge clk_i);
		i_sent_i <= 1'b0;
		@(posedge clk_i);
		i_sent_i <= 1'b1;
		@(posedge clk_i);
		i_sent_i <= 1'b0;
		ex(0, 32'h3);
		rx(LK_RNR, 1'b0, 1'b0, 7'h4);
		settle("peer busy");
		check_count++;
		if (i_tx_en_o !== 1'b0) fail("I frames enabled while busy");
		rd(`LAP_REG_STATUS, 32'h100, 32'h100);
		ex(3, txw(LK_RR, 1'b1, 1'b1));
		settle("busy poll");
		ex(0, 32'h4);
		rx(LK_RR, 1'b0, 1'b1, 7'h5);
		rd(`LAP_REG_STATUS, 32'h0, 32'h300);
		settle("busy cleared");
		check_count++;
		if (i_tx_en_o !== 1'b1) fail("I frames still blocked");
		busy <= 1'b1;
		ex(3, txw(LK_RNR, 1'b0, 1'b1));
		rx(LK_RR, 1'b1, 1'b1, 7'h5);
		settle("own busy poll");
		busy <= 1'b0;
		ex(2, {24'h0, `LAP_ERR_L});
		ex(3, txw(LK_FRMR, 1'b0, 1'b0), 32'h3e);
		ex(3, txw(LK_SABME, 1'b1, 1'b1));
		rx(LK_UNDEF, 1'b1, 1'b0, 7'h0);
		rd(`LAP_REG_STATUS, 32'h04, 32'h1f);
		settle("frame reject");
		rx(LK_UA, 1'b0, 1'b1, 7'h0);
		for (int m = 0; m < 2; m++)
		begin
			wr(`LAP_REG_CTRL, 32'h2 | 32'(m));
			ex(2, {24'h0, `LAP_ERR_B});
			if (m == 1) ex(3, txw(LK_SABME, 1'b1, 1'b1));
			rx(LK_DM, 1'b0, 1'b1, 7'h0);
			rd(`LAP_REG_STATUS, (m == 1) ? 32'h04 : 32'h08, 32'h1f);
			settle("error mode");
		end
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		wr(`LAP_REG_CTRL, 32'h30);
		wr(`LAP_REG_ADDR, {16'h0, la});
		wr(`LAP_REG_CMD, 32'h1);
		r = $urandom();
		ex(4, {14'h0, r[0], r[1], la});
		@(posedge clk_i);
		np_insert_i <= r[0];
		np_crc_i <= r[1];
		np_tx_req_i <= 1'b1;
		@(posedge clk_i);
		np_tx_req_i <= 1'b0;
		i_lap_peer.send_frame(LK_UI, 1'b1, 1'b0, 7'h0, la, 16'h4, 1'b1);
		ex(5, {14'h0, la ^ 16'h0103, 1'b1, 1'b1});
		i_lap_peer.send_frame(LK_UI, 1'b1, 1'b0, 7'h0, la ^ 16'h0103,
			16'h5, 1'b0);
		ex(5, {14'h0, la, 1'b0, 1'b1});
		rx(LK_RR, 1'b0, 1'b0, 7'h3);
		settle("nonprotocol");
		wrap_up;
	end
endmodule
